// file: pkg/monitor_led_regs.svh
/*
 * Register indices, field positions, reset values and timing counts of the
 * monitor and LED configuration bank.
 * Assumes a 250 MHz pclk; byte address on APB is four times the index.
 */
`ifndef MONITOR_LED_REGS_SVH
`define MONITOR_LED_REGS_SVH

`define IDX_FUNCTION_ACTIVATE   8'h30
`define IDX_MONITOR_IO_BASE     8'h60
`define IDX_SIDEBAND_IO_BASE    8'h62
`define IDX_IRQ_SELECT          8'h70
`define IDX_SYSTEM_FAN_DUTY     8'hE0
`define IDX_PROCESSOR_FAN_DUTY  8'hE1
`define IDX_AUXILIARY_FAN_DUTY  8'hE2
`define IDX_TACH_DEBOUNCE_CTRL  8'hF0
`define IDX_SMI_IRQ_CTRL        8'hF1
`define IDX_SMBUS_DEBOUNCE_CTRL 8'hF2
`define IDX_DEEP_S3_LED_CTRL    8'hF3

`define RST_BYTE_ZERO           8'h00
`define RST_BASE_ZERO           16'h0000
`define RST_SYSTEM_FAN_DUTY     8'h7F
`define RST_PROCESSOR_FAN_DUTY  8'h7F
`define RST_AUXILIARY_FAN_DUTY  8'hFF

`define BIT_ACTIVATE            0
`define BIT_TACH_AUX_OFF        7
`define BIT_TACH_CPU_OFF        6
`define BIT_TACH_SYS_OFF        5
`define BIT_SMI_ENABLE          7
`define BIT_SCL_DEB_OFF         1
`define BIT_SDA_DEB_OFF         0
`define BIT_YELLOW_OVERRIDE     7
`define BIT_GREEN_OVERRIDE      6

`define BASE_MIN                16'h0100
`define BASE_MAX                16'h0FFE
`define BASE_MASK               16'h0FFE
`define IRQ_SEL_MASK            8'h0F
`define TACH_CTRL_MASK          8'hE0
`define SMI_CTRL_MASK           8'h80
`define SMB_CTRL_MASK           8'h03

`define CLK_PERIOD_NS           4
`define CLK_KHZ                 250000
`define SMB_DEB_MIN_NS          80
`define SMB_DEB_CYCLES          ((`SMB_DEB_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TACH_DEB_NS             1000
`define TACH_DEB_CYCLES         ((`TACH_DEB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLINK_HALF_MS           250
`define BLINK_TICK_CYCLES       (`BLINK_HALF_MS * `CLK_KHZ)
`define FADE_STEP_US            2000
`define FADE_STEP_CYCLES        (`FADE_STEP_US * (`CLK_KHZ / 1000))

`endif

// file: pkg/monitor_led_pkg.sv
/*
 * Types shared by the monitor and LED configuration bank.
 * Assumes nothing beyond the register header.
 */
package monitor_led_pkg;
	typedef struct packed {
		logic [7:0] system_fan_output;
		logic [7:0] processor_fan_output;
		logic [7:0] auxiliary_fan_output;
	} fan_duty_t;

	typedef struct packed {
		logic system_tach_input;
		logic processor_tach_input;
		logic auxiliary_tach_input;
	} tach_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} smbus_pins_t;

	typedef struct packed {
		logic out;
		logic oe;
	} od_pin_t;

	typedef enum logic [3:0] {
		LED_HIGH_Z   = 4'h0,
		LED_DRIVE_LO = 4'h7
	} led_code_t;
endpackage : monitor_led_pkg

// file: rtl/monitor_led_config_bank.sv
/*
 * Configuration register bank for the hardware monitor, sideband and
 * deep-S3 front panel LEDs, with input debouncers and LED blink logic.
 * Assumes an APB master on pclk, separate standby and battery resets
 * and tachometer and SMBus inputs already synchronous to pclk.
 */
// The APB slave port was left to the implementer.
// Summary of operation
// - Activation bit 0 makes monitor and sideband active when one.
// - Monitor I/O base is 16-bit, 100h to FFEh, even aligned.
// - Sideband I/O base is 16-bit, 100h to FFEh, even aligned.
// - Low nibble of 70h selects monitor IRQ; upper nibble reserved.
// - Three fan duty registers, standby reset to 7Fh, 7Fh, FFh.
// - F0h bits 7,6,5 control aux, processor, system tach debouncers.
// - F1h bit 7 enables routing monitor interrupt as SYSTEM_MANAGEMENT_INTERRUPT.
// - F2h bit 1 zero filters SMBus clock 80 to 120 ns.
// - F2h bit 0 zero filters SMBus data 80 to 120 ns.
// - F3h bits 7-4 drive yellow LED only while override bit 7 is zero.
// - Code 1xxx fades, 0111 drives low, 0000 leaves pin high impedance.
// - Codes 0110 to 0001 blink 2 Hz down to 0.0625 Hz, 50% duty.
// - F3h bits 3-0 drive green LED only while override bit 6 is zero.
// - Deep-S3 LED register cleared only by battery reset.
`timescale 1ns/1ps
`default_nettype none
`include "monitor_led_regs.svh"

module input_filter #(
	parameter int unsigned CYCLES = 20
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic raw,
	input  wire logic bypass,
	output logic      filt
);
	logic [15:0] cnt_r;
	logic        held_r;

	// Output moves only after the input has held its new level CYCLES clocks
	// A bounce restarts the count, so a short glitch never reaches filt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r  <= 16'h0000;
			held_r <= 1'b0;
		end else if (raw == held_r) begin
			cnt_r <= 16'h0000;
		end else if (cnt_r == 16'(CYCLES - 1)) begin
			cnt_r  <= 16'h0000;
			held_r <= raw;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end

	assign filt = bypass ? raw : held_r;
endmodule : input_filter

module led_code_driver (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic [3:0]           code,
	input  wire logic                 override,
	input  wire logic [5:0]           blink_cnt,
	input  wire logic                 fade_on,
	output monitor_led_pkg::od_pin_t  pin
);
	logic phase;

	// Slower codes tap higher counter bits; codes 0 and 7 never blink
	always_comb begin
		unique case (code[2:0])
			3'h6:    phase = blink_cnt[0];
			3'h5:    phase = blink_cnt[1];
			3'h4:    phase = blink_cnt[2];
			3'h3:    phase = blink_cnt[3];
			3'h2:    phase = blink_cnt[4];
			3'h1:    phase = blink_cnt[5];
			default: phase = 1'b0;
		endcase
	end

	// Open-drain: out stays low, only the enable moves
	// Registering the pin keeps code changes glitch free at the pad
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin <= '0;
		end else if (override) begin
			pin <= '0;
		end else if (code[3]) begin
			pin <= '{out: 1'b0, oe: fade_on};
		end else if (code == monitor_led_pkg::LED_DRIVE_LO) begin
			pin <= '{out: 1'b0, oe: 1'b1};
		end else if (code == monitor_led_pkg::LED_HIGH_Z) begin
			pin <= '0;
		end else begin
			pin <= '{out: 1'b0, oe: phase};
		end
	end
endmodule : led_code_driver

module monitor_led_config_bank #(
	parameter int unsigned BLINK_TICK_CYCLES = `BLINK_TICK_CYCLES,
	parameter int unsigned FADE_STEP_CYCLES  = `FADE_STEP_CYCLES
) (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      resume_reset_n,
	input  wire logic                      battery_reset_n,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [31:0]               paddr,
	input  wire logic [31:0]               pwdata,
	input  wire logic [3:0]                pstrb,
	output logic [31:0]                    prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic [1:0]                led_override_register,
	input  wire monitor_led_pkg::tach_t    tach_raw,
	input  wire monitor_led_pkg::smbus_pins_t smbus_raw,
	output monitor_led_pkg::tach_t         tach_filtered,
	output monitor_led_pkg::smbus_pins_t   smbus_filtered,
	output logic                           hardware_monitor_active,
	output logic                           monitor_decode_en,
	output logic                           sideband_decode_en,
	output logic [15:0]                    monitor_io_base,
	output logic [15:0]                    sideband_io_base,
	output logic [3:0]                     hardware_monitor_irq,
	output logic                           system_management_interrupt_en,
	output monitor_led_pkg::fan_duty_t     fan_duty,
	output monitor_led_pkg::od_pin_t       yellow_led_output,
	output monitor_led_pkg::od_pin_t       green_led_output
);
	logic [7:0]  function_activate_r;
	logic [15:0] monitor_io_base_r;
	logic [15:0] sideband_io_base_r;
	logic [7:0]  irq_select_r;
	logic [7:0]  system_fan_duty_r;
	logic [7:0]  processor_fan_duty_r;
	logic [7:0]  auxiliary_fan_duty_r;
	logic [7:0]  tach_debounce_ctrl_r;
	logic [7:0]  smi_irq_ctrl_r;
	logic [7:0]  smbus_debounce_ctrl_r;
	logic [7:0]  deep_s3_led_ctrl_r;
	logic [31:0] prdata_r;
	logic        pslverr_r;
	logic [7:0]  idx;
	logic        hit;
	logic [31:0] rd_nxt;
	logic        wr_en;
	logic        wr_base_ok;
	logic [15:0] base_nxt;
	logic [31:0] blink_div_r;
	logic [5:0]  blink_cnt_r;
	logic [31:0] fade_div_r;
	logic [8:0]  fade_phase_r;
	logic [7:0]  pwm_r;
	logic [7:0]  fade_level;
	logic        fade_on;

	// Word aligned: index is address bits 9:2, upper bits must be zero
	assign idx      = paddr[9:2];
	// Range is judged on the masked value; bit 0 and bits 15:12 are dropped
	assign base_nxt = pwdata[15:0] & `BASE_MASK;
	assign wr_base_ok = (base_nxt >= `BASE_MIN) && (base_nxt <= `BASE_MAX);

	always_comb begin
		hit    = (paddr[31:10] == 22'h000000) && (paddr[1:0] == 2'h0);
		rd_nxt = 32'h00000000;
		unique case (idx)
			`IDX_FUNCTION_ACTIVATE:   rd_nxt[7:0]  = function_activate_r;
			`IDX_MONITOR_IO_BASE:     rd_nxt[15:0] = monitor_io_base_r;
			`IDX_SIDEBAND_IO_BASE:    rd_nxt[15:0] = sideband_io_base_r;
			`IDX_IRQ_SELECT:          rd_nxt[7:0]  = irq_select_r;
			`IDX_SYSTEM_FAN_DUTY:     rd_nxt[7:0]  = system_fan_duty_r;
			`IDX_PROCESSOR_FAN_DUTY:  rd_nxt[7:0]  = processor_fan_duty_r;
			`IDX_AUXILIARY_FAN_DUTY:  rd_nxt[7:0]  = auxiliary_fan_duty_r;
			`IDX_TACH_DEBOUNCE_CTRL:  rd_nxt[7:0]  = tach_debounce_ctrl_r;
			`IDX_SMI_IRQ_CTRL:        rd_nxt[7:0]  = smi_irq_ctrl_r;
			`IDX_SMBUS_DEBOUNCE_CTRL: rd_nxt[7:0]  = smbus_debounce_ctrl_r;
			`IDX_DEEP_S3_LED_CTRL:    rd_nxt[7:0]  = deep_s3_led_ctrl_r;
			default:                  hit          = 1'b0;
		endcase
	end

	// Zero wait: answer data is latched in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= 32'h00000000;
			pslverr_r <= 1'b0;
		end else if (psel && !penable) begin
			prdata_r  <= pwrite ? 32'h00000000 : rd_nxt;
			pslverr_r <= !hit || (pwrite && !pstrb[0]) ||
			             (pwrite && (idx == `IDX_MONITOR_IO_BASE ||
			              idx == `IDX_SIDEBAND_IO_BASE) && !wr_base_ok);
		end
	end

	// Ready is tied high, so a master is never stalled by this bank
	assign pready  = 1'b1;
	assign prdata  = prdata_r;
	assign pslverr = pslverr_r;
	// Refused accesses never write; the error is judged once at setup
	assign wr_en   = psel && penable && pwrite && !pslverr_r;

	// Core well registers, cleared by the bus reset
	// Reserved bits are masked on write so they always read back as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			function_activate_r  <= `RST_BYTE_ZERO;
			monitor_io_base_r    <= `RST_BASE_ZERO;
			sideband_io_base_r   <= `RST_BASE_ZERO;
			irq_select_r         <= `RST_BYTE_ZERO;
			tach_debounce_ctrl_r <= `RST_BYTE_ZERO;
			smi_irq_ctrl_r       <= `RST_BYTE_ZERO;
		end else if (wr_en) begin
			unique case (idx)
				`IDX_FUNCTION_ACTIVATE:
					function_activate_r <= 8'(pwdata[`BIT_ACTIVATE]);
				`IDX_MONITOR_IO_BASE:
					if (pstrb[1])
						monitor_io_base_r <= base_nxt;
				`IDX_SIDEBAND_IO_BASE:
					if (pstrb[1])
						sideband_io_base_r <= base_nxt;
				`IDX_IRQ_SELECT:
					irq_select_r <= pwdata[7:0] & `IRQ_SEL_MASK;
				`IDX_TACH_DEBOUNCE_CTRL:
					tach_debounce_ctrl_r <= pwdata[7:0] & `TACH_CTRL_MASK;
				`IDX_SMI_IRQ_CTRL:
					smi_irq_ctrl_r <= pwdata[7:0] & `SMI_CTRL_MASK;
				default: ;
			endcase
		end
	end

	// Standby well registers survive the bus reset
	always_ff @(posedge pclk or negedge resume_reset_n) begin
		if (!resume_reset_n) begin
			system_fan_duty_r     <= `RST_SYSTEM_FAN_DUTY;
			processor_fan_duty_r  <= `RST_PROCESSOR_FAN_DUTY;
			auxiliary_fan_duty_r  <= `RST_AUXILIARY_FAN_DUTY;
			smbus_debounce_ctrl_r <= `RST_BYTE_ZERO;
		end else if (wr_en) begin
			unique case (idx)
				`IDX_SYSTEM_FAN_DUTY:     system_fan_duty_r    <= pwdata[7:0];
				`IDX_PROCESSOR_FAN_DUTY:  processor_fan_duty_r <= pwdata[7:0];
				`IDX_AUXILIARY_FAN_DUTY:  auxiliary_fan_duty_r <= pwdata[7:0];
				`IDX_SMBUS_DEBOUNCE_CTRL:
					smbus_debounce_ctrl_r <= pwdata[7:0] & `SMB_CTRL_MASK;
				default: ;
			endcase
		end
	end

	// Battery well: only the battery reset clears the LED codes
	always_ff @(posedge pclk or negedge battery_reset_n) begin
		if (!battery_reset_n) begin
			deep_s3_led_ctrl_r <= `RST_BYTE_ZERO;
		end else if (wr_en && idx == `IDX_DEEP_S3_LED_CTRL) begin
			deep_s3_led_ctrl_r <= pwdata[7:0];
		end
	end

	assign hardware_monitor_active = function_activate_r[`BIT_ACTIVATE];
	// Decoding needs both activation and a base inside the legal window
	assign monitor_decode_en  = hardware_monitor_active && (monitor_io_base_r >= `BASE_MIN);
	assign sideband_decode_en = hardware_monitor_active && (sideband_io_base_r >= `BASE_MIN);
	assign monitor_io_base    = monitor_io_base_r;
	assign sideband_io_base   = sideband_io_base_r;
	assign hardware_monitor_irq = irq_select_r[3:0];
	assign system_management_interrupt_en = smi_irq_ctrl_r[`BIT_SMI_ENABLE];
	assign fan_duty = '{system_fan_output:    system_fan_duty_r,
	                    processor_fan_output: processor_fan_duty_r,
	                    auxiliary_fan_output: auxiliary_fan_duty_r};

	// A control bit of one bypasses the filter
	input_filter #(.CYCLES(`TACH_DEB_CYCLES)) u_tach_sys (
		.pclk    (pclk),
		.presetn (presetn),
		.raw     (tach_raw.system_tach_input),
		.bypass  (tach_debounce_ctrl_r[`BIT_TACH_SYS_OFF]),
		.filt    (tach_filtered.system_tach_input)
	);
	input_filter #(.CYCLES(`TACH_DEB_CYCLES)) u_tach_cpu (
		.pclk    (pclk),
		.presetn (presetn),
		.raw     (tach_raw.processor_tach_input),
		.bypass  (tach_debounce_ctrl_r[`BIT_TACH_CPU_OFF]),
		.filt    (tach_filtered.processor_tach_input)
	);
	input_filter #(.CYCLES(`TACH_DEB_CYCLES)) u_tach_aux (
		.pclk    (pclk),
		.presetn (presetn),
		.raw     (tach_raw.auxiliary_tach_input),
		.bypass  (tach_debounce_ctrl_r[`BIT_TACH_AUX_OFF]),
		.filt    (tach_filtered.auxiliary_tach_input)
	);
	// 80 ns minimum at 4 ns is 20 clocks, well below the 120 ns ceiling
	input_filter #(.CYCLES(`SMB_DEB_CYCLES)) u_smb_scl (
		.pclk    (pclk),
		.presetn (presetn),
		.raw     (smbus_raw.scl),
		.bypass  (smbus_debounce_ctrl_r[`BIT_SCL_DEB_OFF]),
		.filt    (smbus_filtered.scl)
	);
	input_filter #(.CYCLES(`SMB_DEB_CYCLES)) u_smb_sda (
		.pclk    (pclk),
		.presetn (presetn),
		.raw     (smbus_raw.sda),
		.bypass  (smbus_debounce_ctrl_r[`BIT_SDA_DEB_OFF]),
		.filt    (smbus_filtered.sda)
	);

	// Reference tick every 250 ms; each counter bit halves the rate
	// Six bits cover all six blink codes; the counter simply wraps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_div_r <= 32'h00000000;
			blink_cnt_r <= 6'h00;
		end else if (blink_div_r == 32'(BLINK_TICK_CYCLES - 1)) begin
			blink_div_r <= 32'h00000000;
			blink_cnt_r <= blink_cnt_r + 6'h01;
		end else begin
			blink_div_r <= blink_div_r + 32'h00000001;
		end
	end

	// Fading is a triangle brightness ramp applied through an 8-bit PWM
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fade_div_r   <= 32'h00000000;
			fade_phase_r <= 9'h000;
			pwm_r        <= 8'h00;
		end else begin
			pwm_r <= pwm_r + 8'h01;
			if (fade_div_r == 32'(FADE_STEP_CYCLES - 1)) begin
				fade_div_r   <= 32'h00000000;
				fade_phase_r <= fade_phase_r + 9'h001;
			end else begin
				fade_div_r <= fade_div_r + 32'h00000001;
			end
		end
	end

	// Mirroring the low bits avoids a brightness jump when the ramp wraps
	assign fade_level = fade_phase_r[8] ? ~fade_phase_r[7:0] : fade_phase_r[7:0];
	// One shared PWM compare keeps both LEDs fading in step
	assign fade_on    = pwm_r < fade_level;

	// Override bits arrive as plain inputs; the override register lives outside
	led_code_driver u_led_yellow (
		.pclk      (pclk),
		.presetn   (presetn),
		.code      (deep_s3_led_ctrl_r[7:4]),
		.override  (led_override_register[1]),
		.blink_cnt (blink_cnt_r),
		.fade_on   (fade_on),
		.pin       (yellow_led_output)
	);
	led_code_driver u_led_green (
		.pclk      (pclk),
		.presetn   (presetn),
		.code      (deep_s3_led_ctrl_r[3:0]),
		.override  (led_override_register[0]),
		.blink_cnt (blink_cnt_r),
		.fade_on   (fade_on),
		.pin       (green_led_output)
	);
endmodule : monitor_led_config_bank
`default_nettype wire

// file: sim/monitor_led_config_bank_sva.sv
/* Port checker for the monitor and LED configuration bank.
   Assumes a bind to the bank and APB byte addresses at four times the index. */
`timescale 1ns/1ps
`default_nettype none
module monitor_led_sva (
	input wire logic                       pclk,
	input wire logic                       presetn,
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [31:0]                paddr,
	input wire logic [31:0]                pwdata,
	input wire logic                       pslverr,
	input wire logic [1:0]                 led_override_register,
	input wire logic                       hardware_monitor_active,
	input wire logic                       monitor_decode_en,
	input wire logic [15:0]                monitor_io_base,
	input wire logic [15:0]                sideband_io_base,
	input wire logic [3:0]                 hardware_monitor_irq,
	input wire logic                       system_management_interrupt_en,
	input wire monitor_led_pkg::fan_duty_t fan_duty,
	input wire monitor_led_pkg::od_pin_t   yellow_led_output,
	input wire monitor_led_pkg::od_pin_t   green_led_output
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Accepted write to one byte address
	sequence s_wr(logic [31:0] a);
		psel && penable && pwrite && !pslverr && paddr == a;
	endsequence
	a_active_bit: assert property (s_wr(32'h000000C0)
		|=> hardware_monitor_active == $past(pwdata[0])) else $error("activation bit lost");
	a_mon_decode: assert property (
		monitor_decode_en == (hardware_monitor_active && monitor_io_base >= 16'h0100))
		else $error("monitor decode mismatch");
	a_mon_range: assert property (monitor_io_base == 16'h0000 ||
		(monitor_io_base inside {[16'h0100:16'h0FFE]} && !monitor_io_base[0]))
		else $error("monitor base out of range");
	a_sb_range: assert property (sideband_io_base == 16'h0000 ||
		(sideband_io_base inside {[16'h0100:16'h0FFE]} && !sideband_io_base[0]))
		else $error("sideband base out of range");
	a_irq_sel: assert property (s_wr(32'h000001C0)
		|=> hardware_monitor_irq == $past(pwdata[3:0])) else $error("irq select lost");
	a_fan_write: assert property (s_wr(32'h00000388)
		|=> fan_duty.auxiliary_fan_output == $past(pwdata[7:0])) else $error("fan duty lost");
	a_smi_route: assert property (s_wr(32'h000003C4)
		|=> system_management_interrupt_en == $past(pwdata[7])) else $error("smi enable lost");
	a_ylw_release: assert property (led_override_register[1]
		|=> !yellow_led_output.oe) else $error("yellow not released");
	a_grn_release: assert property (led_override_register[0]
		|=> !green_led_output.oe) else $error("green not released");
	a_od_low_only: assert property (
		!yellow_led_output.out && !green_led_output.out) else $error("led driven high");
endmodule : monitor_led_sva
bind monitor_led_config_bank monitor_led_sva i_monitor_led_sva (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pslverr(pslverr), .led_override_register(led_override_register),
	.hardware_monitor_active(hardware_monitor_active), .monitor_decode_en(monitor_decode_en),
	.monitor_io_base(monitor_io_base), .sideband_io_base(sideband_io_base),
	.hardware_monitor_irq(hardware_monitor_irq),
	.system_management_interrupt_en(system_management_interrupt_en), .fan_duty(fan_duty),
	.yellow_led_output(yellow_led_output), .green_led_output(green_led_output));
`default_nettype wire

// file: sim/testbench.sv
/* Self-checking bench for the monitor and LED configuration bank.
   Assumes pready answers every access and a short blink tick. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int TICK = 8;
	logic                         pclk = 1'b0;
	logic                         presetn = 1'b0;
	logic                         rsm_n = 1'b0;
	logic                         bat_n = 1'b0;
	logic                         psel = 1'b0;
	logic                         penable = 1'b0;
	logic                         pwrite = 1'b0;
	logic [31:0]                  paddr = 32'h0;
	logic [31:0]                  pwdata = 32'h0;
	logic [31:0]                  prdata;
	logic                         pready;
	logic                         pslverr;
	logic [1:0]                   ovr = 2'b00;
	logic [3:0]                   strb = 4'hF;
	monitor_led_pkg::tach_t       tach = '0;
	monitor_led_pkg::tach_t       tach_f;
	monitor_led_pkg::smbus_pins_t smb = '0;
	monitor_led_pkg::smbus_pins_t smb_f;
	monitor_led_pkg::fan_duty_t   fan;
	monitor_led_pkg::od_pin_t     ylw;
	monitor_led_pkg::od_pin_t     grn;
	logic                         act;
	logic                         mon_en;
	logic                         sb_en;
	logic                         system_management_interrupt;
	logic [15:0]                  mon_b;
	logic [15:0]                  sb_b;
	logic [3:0]                   irq;
	logic [31:0]                  rd;
	logic                         err;
	int                           n_fail = 0;
	int                           check_count = 0;
	always #2 pclk = ~pclk;
	monitor_led_config_bank #(.BLINK_TICK_CYCLES(TICK), .FADE_STEP_CYCLES(2))
	i_monitor_led_config_bank (.pclk(pclk), .presetn(presetn), .resume_reset_n(rsm_n),
		.battery_reset_n(bat_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .led_override_register(ovr), .tach_raw(tach), .smbus_raw(smb),
		.tach_filtered(tach_f), .smbus_filtered(smb_f), .hardware_monitor_active(act),
		.monitor_decode_en(mon_en), .sideband_decode_en(sb_en), .monitor_io_base(mon_b),
		.sideband_io_base(sb_b), .hardware_monitor_irq(irq),
		.system_management_interrupt_en(system_management_interrupt), .fan_duty(fan), .yellow_led_output(ylw),
		.green_led_output(grn));
	task automatic conclude;
		if (n_fail == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Settle after the edge so registered outputs have landed
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : cyc
	task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {22'h0, idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (i >= 50) begin
			n_fail++;
			conclude();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic e);
		apb(1'b1, idx, d);
		chk(32'(err), 32'(e));
	endtask : wr
	task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
		apb(1'b0, idx, 32'h0);
		chk(32'(err), 32'h0);
		chk(rd, e);
	endtask : rdc
	task automatic t_defaults;
		logic [7:0] ix [11] = '{8'h30, 8'h60, 8'h62, 8'h70, 8'hE0, 8'hE1, 8'hE2, 8'hF0,
			8'hF1, 8'hF2, 8'hF3};
		logic [7:0] dv [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h7F, 8'h7F, 8'hFF, 8'h00,
			8'h00, 8'h00, 8'h00};
		for (int k = 0; k < 11; k++) begin
			rdc(ix[k], {24'h0, dv[k]});
		end
		apb(1'b0, 8'h61, 32'h0);
		chk(32'(err), 32'h1);
	endtask : t_defaults
	task automatic t_masks;
		logic [7:0] ix [9] = '{8'h30, 8'h70, 8'hE0, 8'hE1, 8'hE2, 8'hF0, 8'hF1, 8'hF2, 8'hF3};
		logic [7:0] mk [9] = '{8'h01, 8'h05, 8'hA5, 8'hA5, 8'hA5, 8'hA0, 8'h80, 8'h01, 8'hA5};
		for (int k = 0; k < 9; k++) begin
			wr(ix[k], 32'hA5, 1'b0);
			rdc(ix[k], {24'h0, mk[k]});
		end
		chk(32'(act), 32'h1);
		chk(32'(irq), 32'h5);
		chk(32'(system_management_interrupt), 32'h1);
		chk(32'(fan), 32'hA5A5A5);
		wr(8'h30, 32'h0, 1'b0);
		cyc(1);
		chk(32'(act), 32'h0);
	endtask : t_masks
	task automatic t_base;
		wr(8'h30, 32'h1, 1'b0);
		wr(8'h60, 32'h0FFF, 1'b0);
		rdc(8'h60, 32'h0FFE);
		chk({mon_b, 15'h0, mon_en}, 32'h0FFE0001);
		wr(8'h60, 32'h00FE, 1'b1);
		rdc(8'h60, 32'h0FFE);
		wr(8'h62, 32'h0100, 1'b0);
		wr(8'h62, 32'h1000, 1'b1);
		rdc(8'h62, 32'h0100);
		chk({sb_b, 15'h0, sb_en}, 32'h01000001);
		@(posedge pclk);
		strb <= 4'h0;
		wr(8'h70, 32'h3, 1'b1);
		rdc(8'h70, 32'h5);
		@(posedge pclk);
		strb <= 4'h1;
		wr(8'h60, 32'h0200, 1'b0);
		rdc(8'h60, 32'h0FFE);
		@(posedge pclk);
		strb <= 4'hF;
	endtask : t_base
	task automatic t_filt;
		wr(8'hF2, 32'h0, 1'b0);
		wr(8'hF0, 32'h0, 1'b0);
		@(posedge pclk);
		smb <= 2'b11;
		tach <= 3'b111;
		cyc(10);
		chk(32'(smb_f), 32'h0);
		cyc(15);
		chk(32'(smb_f), 32'h3);
		cyc(200);
		chk(32'(tach_f), 32'h0);
		cyc(60);
		chk(32'(tach_f), 32'h7);
		wr(8'hF2, 32'h1, 1'b0);
		wr(8'hF0, 32'h20, 1'b0);
		@(posedge pclk);
		smb <= 2'b00;
		tach <= 3'b000;
		#1;
		chk(32'(smb_f), 32'h2);
		chk(32'(tach_f), 32'h3);
	endtask : t_filt
	// Half period of the yellow blink, edge to edge
	task automatic half(output int n);
		logic v;
		int i;
		cyc(1);
		v = ylw.oe;
		for (i = 0; i < 600 && ylw.oe === v; i++) cyc(1);
		v = ylw.oe;
		for (n = 0; n < 600 && ylw.oe === v; n++) cyc(1);
		if (n >= 600) begin
			n_fail++;
			conclude();
		end
	endtask : half
	task automatic t_led;
		int n;
		int h;
		wr(8'hF3, 32'h70, 1'b0);
		cyc(2);
		chk({ylw.oe, grn.oe}, 32'h2);
		@(posedge pclk);
		ovr <= 2'b10;
		cyc(2);
		chk(32'(ylw.oe), 32'h0);
		@(posedge pclk);
		ovr <= 2'b00;
		wr(8'hF3, 32'h07, 1'b0);
		cyc(2);
		chk({ylw.oe, grn.oe}, 32'h1);
		@(posedge pclk);
		ovr <= 2'b01;
		cyc(2);
		chk(32'(grn.oe), 32'h0);
		for (int c = 6; c >= 1; c--) begin
			wr(8'hF3, 32'(c << 4), 1'b0);
			half(n);
			chk(32'(n), 32'(TICK << (6 - c)));
		end
		wr(8'hF3, 32'h80, 1'b0);
		h = 0;
		for (int k = 0; k < 2000; k++) begin
			cyc(1);
			h += (ylw.oe === 1'b1);
		end
		chk(32'(h > 0 && h < 2000), 32'h1);
	endtask : t_led
	task automatic t_wells;
		wr(8'hF3, 32'h5A, 1'b0);
		wr(8'hE0, 32'h12, 1'b0);
		wr(8'h30, 32'h1, 1'b0);
		@(posedge pclk);
		presetn <= 1'b0;
		rsm_n <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rsm_n <= 1'b1;
		rdc(8'hF3, 32'h5A);
		rdc(8'hE0, 32'h7F);
		rdc(8'h30, 32'h0);
		rdc(8'hF2, 32'h0);
		@(posedge pclk);
		bat_n <= 1'b0;
		repeat (2) @(posedge pclk);
		bat_n <= 1'b1;
		rdc(8'hF3, 32'h0);
	endtask : t_wells
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rsm_n <= 1'b1;
		bat_n <= 1'b1;
		t_defaults();
		t_masks();
		t_base();
		t_filt();
		t_led();
		t_wells();
		conclude();
	end
endmodule : testbench
`default_nettype wire
